// ===== rtl/sbah_arbiter.sv
// Shared external bus arbiter and host port for one processor of a four-processor module.
// Assumes all pins reach it as separate input, output and output-enable signals;
// the testbench resolves the wired lines. Output enables are active low.
//
// Behaviour
// - As synchronous slave, drive wait handshake low while internal access needs time.
// - Master keeps wait handshake input at its last driven level when undriven.
// - Suspend sampled low floats address, data, selects and strobes next cycle.
// - External access under suspend stalls and completes only after suspend releases.
// - Host requests bus; master floats bus lines and asserts host grant.
// - Host bus request beats every processor bus request; the master keeps the bus while its core external request stands.
// - Host grant stays low while host request is held, released after removal.
// - Only the bus owner drives host grant; others just monitor it.
// - Host ready pulled low during asynchronous host access until it can complete.
// - Host ready is open drain after reset; a config bit selects push-pull.
// - Host ready driven only while chip select and host request are asserted.
// - Drive only own bus request line by identity; watch all others.
// - Rotating priority when select input high, fixed priority when low.
// - Slave core priority access pauses master background DMA; bus ownership does not change.
// - External DMA requests map to channels 7 and 8, answered on grants.
// - Three-state bus pins float under suspend or when processor is a slave.
// - Asynchronous host request and chip selects are synchronised before use.
`timescale 1ns/100ps
`default_nettype none
module sbah_arbiter
   import sbah_pkg::*;
#(
   parameter int SLV_WAIT = SBAH_SLV_WAIT_CYC
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_srst,
   // Configuration
   input wire logic [SBAH_ID_W-1:0] i_proc_identity,
   input wire logic [SBAH_CS_W-1:0] i_cs_index,
   input wire logic i_host_ready_drive_mode,
   input wire logic i_rotating_priority_select,
   // Core side
   input wire logic i_core_ext_req,
   input wire logic i_core_ext_last,
   input wire logic i_dma_bg_req,
   input wire logic i_slave_access,
   input wire logic i_int_busy,
   output logic o_core_stall,
   output logic o_dma_pause,
   output logic o_bus_master,
   output logic o_ext_dma_req_1,
   output logic o_ext_dma_req_2,
   input wire logic i_ext_dma_done_1,
   input wire logic i_ext_dma_done_2,
   // Memory wait handshake pin
   input wire logic i_mem_wait,
   output logic o_mem_wait,
   output logic o_mem_wait_oe_n,
   output logic o_mem_wait_kept,
   // Suspend and bus float
   input wire logic i_suspend_bus_float_n,
   output logic o_bus_float_oe_n,
   // Host pins
   input wire logic i_host_bus_request_n,
   input wire logic [SBAH_NUM_CS-1:0] i_proc_select_n,
   input wire logic i_host_bus_grant_n,
   output logic o_host_bus_grant_n,
   output logic o_host_bus_grant_oe_n,
   output logic o_host_ready_wait,
   output logic o_host_ready_wait_oe_n,
   // Processor bus request lines
   input wire logic [SBAH_NUM_REQ-1:0] i_proc_bus_request_lines_n,
   output logic [SBAH_NUM_REQ-1:0] o_proc_bus_request_lines_n,
   output logic [SBAH_NUM_REQ-1:0] o_proc_bus_request_lines_oe_n,
   // Core priority access
   input wire logic i_core_priority_access_n,
   input wire logic i_core_prio_want,
   output logic o_core_priority_access_oe_n,
   // External DMA pins
   input wire logic i_ext_dma_request_1_n,
   input wire logic i_ext_dma_request_2_n,
   output logic o_ext_dma_grant_1_n,
   output logic o_ext_dma_grant_2_n,
   output logic o_ext_dma_grant_oe_n
);
   localparam int NQ = SBAH_NUM_REQ;
   localparam int NS = 6 + NQ + SBAH_NUM_CS;

   logic [NS-1:0] pin_raw;
   logic [NS-1:0] sync_1;
   logic [NS-1:0] sync_2;
   logic sbf_n, host_req_n, host_grant_in_n, prio_access_n, dr1_n, dr2_n, wait_in;
   logic [NQ-1:0] brq_n;
   logic [SBAH_NUM_CS-1:0] cs_n;
   logic [NQ-1:0] own_bit;
   logic [NQ-1:0] req;
   logic [NQ-1:0] pick;
   logic [SBAH_ID_W-1:0] last_owner;
   logic [SBAH_ID_W-1:0] my_idx;
   sbah_own_t own;
   logic kept;
   logic float_q;
   logic host_acc;
   logic [2:0] slv_cnt;
   logic slv_wait;
   logic g1, g2;
   logic win;

   // Two-flop synchronisers for every pin input
   assign pin_raw = {i_suspend_bus_float_n, i_host_bus_request_n, i_host_bus_grant_n,
                     i_core_priority_access_n, i_ext_dma_request_1_n, i_ext_dma_request_2_n,
                     i_proc_bus_request_lines_n, i_proc_select_n};
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         sync_1 <= '1;
         sync_2 <= '1;
      end else begin
         sync_1 <= pin_raw;
         sync_2 <= sync_1;
      end
   end
   assign {sbf_n, host_req_n, host_grant_in_n, prio_access_n, dr1_n, dr2_n, brq_n, cs_n} = sync_2;

   // Wait handshake input synchronised separately
   logic wait_s1, wait_s2;
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         wait_s1 <= 1'b1;
         wait_s2 <= 1'b1;
      end else begin
         wait_s1 <= i_mem_wait;
         wait_s2 <= wait_s1;
      end
   end
   assign wait_in = wait_s2;

   // Own request line and the set of all requesters
   assign my_idx = (i_proc_identity == SBAH_ID_NONE) ? SBAH_ID_W'(0) : i_proc_identity - 3'h1;
   generate
      for (genvar k = 0; k < NQ; k++) begin : g_req
         assign own_bit[k] = (my_idx == SBAH_ID_W'(k));
         assign req[k] = own_bit[k] ? (i_core_ext_req | i_dma_bg_req) : ~brq_n[k];
         // Drive only the line of this identity, float the others
         assign o_proc_bus_request_lines_oe_n[k] = ~own_bit[k];
         assign o_proc_bus_request_lines_n[k] = ~(i_core_ext_req | i_dma_bg_req);
      end
   endgenerate

   // Priority pick: fixed from line 0, or rotating past the last owner
   always_comb begin
      int idx;
      idx = 0;
      pick = '0;
      if (i_rotating_priority_select) begin
         for (int n = 1; n <= NQ; n++) begin
            idx = (int'(last_owner) + n) % NQ;
            if (req[idx] && pick == '0) pick[idx] = 1'b1;
         end
      end else begin
         for (int n = NQ - 1; n >= 0; n--) begin
            if (req[n]) pick = NQ'(1) << n;
         end
      end
   end
   assign win = |(pick & own_bit);

   // Ownership machine; master drops to idle only at a bus-cycle end
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         own <= SBAH_OWN_IDLE;
         last_owner <= '0;
      end else begin
         unique case (own)
            SBAH_OWN_IDLE: begin
               if (!host_req_n) own <= SBAH_OWN_HOST;
               // A grant still seen low on the shared line means the host holds the bus
               else if (win && host_grant_in_n) begin
                  own <= SBAH_OWN_MASTER;
                  last_owner <= my_idx;
               end
            end
            SBAH_OWN_MASTER: begin
               if (!host_req_n && !i_core_ext_req) own <= SBAH_OWN_HOST;
               else if (i_core_ext_last && !win) own <= SBAH_OWN_IDLE;
            end
            SBAH_OWN_HOST: begin
               if (host_req_n) own <= SBAH_OWN_IDLE;
            end
         endcase
      end
   end
   assign o_bus_master = (own == SBAH_OWN_MASTER);

   // Host grant: owner drives it low while the request stands
   logic was_owner;
   always_ff @(posedge i_mclk) begin
      if (i_srst) was_owner <= 1'b0;
      else if (own == SBAH_OWN_MASTER) was_owner <= 1'b1;
      else if (own == SBAH_OWN_HOST && host_req_n) was_owner <= 1'b0;
      else if (own == SBAH_OWN_IDLE) was_owner <= 1'b0;
   end
   assign o_host_bus_grant_oe_n = ~(was_owner && own == SBAH_OWN_HOST);
   assign o_host_bus_grant_n = ~(own == SBAH_OWN_HOST && !host_req_n);

   // Bus float one cycle after suspend is sampled, or when not master
   always_ff @(posedge i_mclk) begin
      if (i_srst) float_q <= 1'b1;
      else float_q <= !sbf_n || own != SBAH_OWN_MASTER;
   end
   assign o_bus_float_oe_n = float_q;

   // Core stall on suspend, memory wait or lack of ownership
   assign o_core_stall = i_core_ext_req && (!sbf_n || own != SBAH_OWN_MASTER || !kept);
   assign o_dma_pause = i_dma_bg_req && !prio_access_n;
   assign o_core_priority_access_oe_n = ~(i_core_prio_want && own != SBAH_OWN_MASTER);

   // Keeper holding the last driven wait level
   always_ff @(posedge i_mclk) begin
      if (i_srst) kept <= 1'b1;
      else kept <= wait_in;
   end
   assign o_mem_wait_kept = kept;

   // Slave wait: extend synchronous internal access
   always_ff @(posedge i_mclk) begin
      if (i_srst) slv_cnt <= SBAH_WAIT_W_RST;
      else if (!i_slave_access) slv_cnt <= SBAH_WAIT_W_RST;
      else if (slv_cnt < 3'(SLV_WAIT)) slv_cnt <= slv_cnt + 3'h1;
   end
   assign slv_wait = i_slave_access && (slv_cnt < 3'(SLV_WAIT) || i_int_busy);
   assign o_mem_wait = 1'b0;
   assign o_mem_wait_oe_n = ~slv_wait;

   // Host ready: only while selected and host request asserted
   assign host_acc = !cs_n[i_cs_index] && !host_req_n;
   always_comb begin
      o_host_ready_wait = !i_int_busy;
      if (!host_acc) o_host_ready_wait_oe_n = 1'b1;
      else if (i_host_ready_drive_mode) o_host_ready_wait_oe_n = 1'b0;
      else o_host_ready_wait_oe_n = !i_int_busy;
   end

   // External DMA grants for channels 7 and 8
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         g1 <= 1'b0;
         g2 <= 1'b0;
      end else begin
         g1 <= !dr1_n && own == SBAH_OWN_MASTER && !i_ext_dma_done_1;
         g2 <= !dr2_n && own == SBAH_OWN_MASTER && !i_ext_dma_done_2;
      end
   end
   assign o_ext_dma_req_1 = !dr1_n;
   assign o_ext_dma_req_2 = !dr2_n;
   assign o_ext_dma_grant_1_n = ~g1;
   assign o_ext_dma_grant_2_n = ~g2;
   assign o_ext_dma_grant_oe_n = float_q;

   // Checks
   host_first_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (own == SBAH_OWN_IDLE && !host_req_n) |=> own == SBAH_OWN_HOST)
      else $error("host request not first");
   float_next_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !sbf_n |=> o_bus_float_oe_n) else $error("bus not floated");
   grant_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (own == SBAH_OWN_HOST && !host_req_n) |-> !o_host_bus_grant_n)
      else $error("host grant dropped");
   ready_gate_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !host_acc |-> o_host_ready_wait_oe_n) else $error("ready driven unselected");
   stall_susp_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_core_ext_req && !sbf_n) |-> o_core_stall) else $error("no stall");
   one_line_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      $onehot(~o_proc_bus_request_lines_oe_n)) else $error("wrong request line");
   dma_pause_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (i_dma_bg_req && !prio_access_n) |-> o_dma_pause) else $error("dma not paused");
   slave_float_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      (own != SBAH_OWN_MASTER) |=> o_bus_float_oe_n) else $error("slave drives bus");
   grant_owner_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      !o_host_bus_grant_oe_n |-> own == SBAH_OWN_HOST) else $error("grant by non owner");
   wait_slave_a: assert property (@(posedge i_mclk) disable iff (i_srst)
      $rose(i_slave_access) |-> !o_mem_wait_oe_n) else $error("no slave wait");
endmodule // sbah_arbiter
`default_nettype wire

// ===== shared/sbah_pkg.sv
// Package for the shared-bus arbitration and host port block.
// Assumes a single 20 MHz clock; all pin inputs are synchronised in the block.
package sbah_pkg;
   localparam int SBAH_NUM_REQ = 6;        // Bus request lines on the shared bus
   localparam int SBAH_ID_W = 3;           // Width of processor identity
   localparam int SBAH_NUM_CS = 4;         // Host chip selects, one per processor
   localparam int SBAH_CS_W = 2;           // Index width of a chip select
   localparam logic [2:0] SBAH_ID_NONE = 3'h0; // Identity 0 means single processor
   localparam logic [3:0] SBAH_DMA_CH_1 = 4'h7; // Channel served by request 1
   localparam logic [3:0] SBAH_DMA_CH_2 = 4'h8; // Channel served by request 2
   localparam int SBAH_SLV_WAIT_NS = 100;  // Default internal access latency
   localparam int SBAH_CLK_NS = 50;
   localparam int SBAH_SLV_WAIT_CYC =
      (SBAH_SLV_WAIT_NS + SBAH_CLK_NS - 1) / SBAH_CLK_NS;
   localparam logic [2:0] SBAH_WAIT_W_RST = 3'h0;
   typedef enum logic [1:0] {SBAH_OWN_IDLE, SBAH_OWN_MASTER, SBAH_OWN_HOST} sbah_own_t;
endpackage : sbah_pkg

// ===== dv/sbah_far_side.sv
// Far-side model: host, peer processors, memory and board pull-ups on the shared pins.
// Assumes the bench steers it by levels and it sees the arbiter's drives and enables.
`timescale 1ns/100ps
`default_nettype none
module sbah_far_side (
   // Commands from the bench
   input wire logic i_host_want,
   input wire logic [3:0] i_cs_want,
   input wire logic i_mem_stretch,
   input wire logic [3:0] i_peer_req,
   input wire logic i_peer_prio,
   // Arbiter drives and enables
   input wire logic i_wait_drv,
   input wire logic i_wait_oe_n,
   input wire logic i_grant_drv,
   input wire logic i_grant_oe_n,
   input wire logic [5:0] i_req_drv,
   input wire logic [5:0] i_req_oe_n,
   input wire logic i_prio_oe_n,
   // Resolved pins
   output logic o_host_req_n,
   output logic [3:0] o_cs_n,
   output logic o_wait,
   output logic [5:0] o_req_n,
   output logic o_grant_n,
   output logic o_prio_n
);
   // Host asks for the bus and picks one processor by its own select
   assign o_host_req_n = !i_host_want;
   assign o_cs_n = ~i_cs_want;
   // Memory stretches the access unless the slave drives the line itself
   assign o_wait = !i_wait_oe_n ? i_wait_drv : !i_mem_stretch;
   // The previous owner is idle and holds the grant high; the arbiter only monitors it then
   assign o_grant_n = !i_grant_oe_n ? i_grant_drv : 1'b1;
   // Open-drain priority line with pull-up
   assign o_prio_n = !(!i_prio_oe_n || i_peer_prio);
   // Peers drive lines one to four, board pulls five and six high
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         o_req_n[i] = !i_req_oe_n[i] ? i_req_drv[i] : ((i < 4) ? !i_peer_req[i] : 1'b1);
      end
   end
endmodule // sbah_far_side
`default_nettype wire

// ===== dv/sbah_arbiter_tb.sv
// Bench for the arbiter: ownership, host grant, suspend, waits, priority access and DMA.
// Assumes the far-side model resolves every wired pin from the arbiter's enables.
`timescale 1ns/100ps
`default_nettype none
module sbah_arbiter_tb;
   import sbah_pkg::*;
   logic i_mclk, i_srst, i_host_ready_drive_mode, i_rotating_priority_select, i_core_ext_req;
   logic i_core_ext_last, i_dma_bg_req, i_slave_access, i_int_busy, i_ext_dma_done_1, i_ext_dma_done_2;
   logic i_suspend_bus_float_n, i_core_prio_want, i_ext_dma_request_1_n, i_ext_dma_request_2_n;
   logic host_want, mem_stretch, peer_prio;
   logic [2:0] i_proc_identity;
   logic [1:0] i_cs_index;
   logic [3:0] cs_want, peer_req;
   wire logic i_mem_wait, i_host_bus_request_n, i_host_bus_grant_n, i_core_priority_access_n;
   wire logic [3:0] i_proc_select_n;
   wire logic [5:0] i_proc_bus_request_lines_n;
   logic o_core_stall, o_dma_pause, o_bus_master, o_ext_dma_req_1, o_ext_dma_req_2, o_mem_wait;
   logic o_mem_wait_oe_n, o_mem_wait_kept, o_bus_float_oe_n, o_host_bus_grant_n, o_host_bus_grant_oe_n;
   logic o_host_ready_wait, o_host_ready_wait_oe_n, o_core_priority_access_oe_n;
   logic o_ext_dma_grant_1_n, o_ext_dma_grant_2_n, o_ext_dma_grant_oe_n;
   logic [5:0] o_proc_bus_request_lines_n, o_proc_bus_request_lines_oe_n;
   int n_fail = 0;
   int samples_checked = 0;

   sbah_arbiter u_sbah_arbiter (.i_mclk, .i_srst, .i_proc_identity, .i_cs_index, .i_host_ready_drive_mode,
      .i_rotating_priority_select, .i_core_ext_req, .i_core_ext_last, .i_dma_bg_req, .i_slave_access, .i_int_busy,
      .o_core_stall, .o_dma_pause, .o_bus_master, .o_ext_dma_req_1, .o_ext_dma_req_2, .i_ext_dma_done_1,
      .i_ext_dma_done_2, .i_mem_wait, .o_mem_wait, .o_mem_wait_oe_n, .o_mem_wait_kept, .i_suspend_bus_float_n,
      .o_bus_float_oe_n, .i_host_bus_request_n, .i_proc_select_n, .i_host_bus_grant_n, .o_host_bus_grant_n,
      .o_host_bus_grant_oe_n, .o_host_ready_wait, .o_host_ready_wait_oe_n, .i_proc_bus_request_lines_n,
      .o_proc_bus_request_lines_n, .o_proc_bus_request_lines_oe_n, .i_core_priority_access_n, .i_core_prio_want,
      .o_core_priority_access_oe_n, .i_ext_dma_request_1_n, .i_ext_dma_request_2_n, .o_ext_dma_grant_1_n,
      .o_ext_dma_grant_2_n, .o_ext_dma_grant_oe_n);
   sbah_far_side u_sbah_far_side (.i_host_want(host_want), .i_cs_want(cs_want), .i_mem_stretch(mem_stretch),
      .i_peer_req(peer_req), .i_peer_prio(peer_prio), .i_wait_drv(o_mem_wait), .i_wait_oe_n(o_mem_wait_oe_n),
      .i_grant_drv(o_host_bus_grant_n), .i_grant_oe_n(o_host_bus_grant_oe_n), .i_req_drv(o_proc_bus_request_lines_n),
      .i_req_oe_n(o_proc_bus_request_lines_oe_n), .i_prio_oe_n(o_core_priority_access_oe_n),
      .o_host_req_n(i_host_bus_request_n), .o_cs_n(i_proc_select_n), .o_wait(i_mem_wait),
      .o_req_n(i_proc_bus_request_lines_n), .o_grant_n(i_host_bus_grant_n), .o_prio_n(i_core_priority_access_n));

   // Clock generator, 50 ns period
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   // Land just after the n-th next rising edge
   task automatic step(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic check(input string what, input logic [5:0] seen, input logic [5:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic t_idle_slave();
      check("own line enable", o_proc_bus_request_lines_oe_n, 6'h3D);
      check("idle float", o_bus_float_oe_n, 6'h01);
      i_slave_access = 1'b1;
      i_int_busy = 1'b1;
      step(2);
      check("slave wait drive", {o_mem_wait_oe_n, o_mem_wait}, 6'h00);
      i_slave_access = 1'b0;
      i_int_busy = 1'b0;
      step(4);
      check("slave wait off", o_mem_wait_oe_n, 6'h01);
   endtask
   task automatic t_priority();
      // Peer line must be through the synchroniser before the core asks
      peer_req[0] = 1'b1;
      step(3);
      i_core_ext_req = 1'b1;
      step(3);
      check("lower line wins", o_bus_master, 6'h00);
      check("stall off bus", o_core_stall, 6'h01);
      host_want = 1'b1;
      peer_req[0] = 1'b0;
      step(5);
      check("host beats core", o_bus_master, 6'h00);
      host_want = 1'b0;
      step(6);
      check("core owns bus", o_bus_master, 6'h01);
      check("master drives", o_bus_float_oe_n, 6'h00);
   endtask
   task automatic t_host_grant();
      i_core_ext_req = 1'b0;
      host_want = 1'b1;
      cs_want = 4'h1;
      step(4);
      check("grant drive", {o_host_bus_grant_oe_n, o_host_bus_grant_n}, 6'h00);
      check("float for host", o_bus_float_oe_n, 6'h01);
      check("ready driven", o_host_ready_wait_oe_n, 6'h00);
      i_host_ready_drive_mode = 1'b0;
      i_int_busy = 1'b1;
      step(1);
      check("ready open drain low", {o_host_ready_wait_oe_n, o_host_ready_wait}, 6'h00);
      i_int_busy = 1'b0;
      step(1);
      check("ready open drain off", o_host_ready_wait_oe_n, 6'h01);
      i_host_ready_drive_mode = 1'b1;
      step(8);
      check("grant held", o_host_bus_grant_n, 6'h00);
      cs_want = 4'h0;
      step(3);
      check("ready undriven", o_host_ready_wait_oe_n, 6'h01);
      host_want = 1'b0;
      step(4);
      check("grant off", o_host_bus_grant_oe_n, 6'h01);
   endtask
   task automatic t_suspend();
      i_core_ext_req = 1'b1;
      step(6);
      i_suspend_bus_float_n = 1'b0;
      step(3);
      check("suspend float", {o_bus_float_oe_n, o_core_stall}, 6'h03);
      i_suspend_bus_float_n = 1'b1;
      step(3);
      check("resume", {o_bus_float_oe_n, o_core_stall}, 6'h00);
      mem_stretch = 1'b1;
      step(3);
      check("wait kept", {o_mem_wait_kept, o_core_stall}, 6'h01);
      mem_stretch = 1'b0;
      step(3);
      check("wait over", o_core_stall, 6'h00);
   endtask
   task automatic t_dma();
      i_dma_bg_req = 1'b1;
      peer_prio = 1'b1;
      step(3);
      check("dma pause", o_dma_pause, 6'h01);
      peer_prio = 1'b0;
      i_ext_dma_request_1_n = 1'b0;
      i_ext_dma_request_2_n = 1'b0;
      step(4);
      check("dma req 7 8", {o_ext_dma_req_1, o_ext_dma_req_2}, 6'h03);
      check("dma grants", {o_ext_dma_grant_oe_n, o_ext_dma_grant_1_n, o_ext_dma_grant_2_n}, 6'h00);
      i_ext_dma_done_1 = 1'b1;
      step(1);
      check("dma grant 1 done", {o_ext_dma_grant_1_n, o_ext_dma_grant_2_n}, 6'h02);
      i_ext_dma_done_1 = 1'b0;
      i_ext_dma_request_1_n = 1'b1;
      i_ext_dma_request_2_n = 1'b1;
   endtask
   // Rotating against fixed priority with a peer on line 2 and the core on line 1
   task automatic t_rotate();
      i_core_ext_req = 1'b0;
      i_dma_bg_req = 1'b0;
      i_core_ext_last = 1'b1;
      step(1);
      i_core_ext_last = 1'b0;
      check("release at cycle end", o_bus_master, 6'h00);
      i_rotating_priority_select = 1'b1;
      peer_req[2] = 1'b1;
      i_core_prio_want = 1'b1;
      step(3);
      check("priority line drive", o_core_priority_access_oe_n, 6'h00);
      i_core_ext_req = 1'b1;
      step(3);
      check("rotation passes on", o_bus_master, 6'h00);
      check("own request drive", o_proc_bus_request_lines_n[1], 6'h00);
      i_rotating_priority_select = 1'b0;
      step(2);
      check("fixed lowest wins", o_bus_master, 6'h01);
      check("priority line off", o_core_priority_access_oe_n, 6'h01);
      i_core_prio_want = 1'b0;
      peer_req = 4'h0;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {i_srst, i_suspend_bus_float_n, i_ext_dma_request_1_n, i_ext_dma_request_2_n} = 4'hF;
      {i_core_ext_req, i_core_ext_last, i_dma_bg_req, i_slave_access, i_int_busy} = 5'h00;
      {i_ext_dma_done_1, i_ext_dma_done_2, i_core_prio_want, i_rotating_priority_select} = 4'h0;
      {host_want, mem_stretch, peer_prio, cs_want, peer_req} = 11'h000;
      i_host_ready_drive_mode = 1'b1;
      i_proc_identity = 3'h2;
      i_cs_index = 2'h0;
      step(10);
      i_srst = 1'b0;
      step(1);
      t_idle_slave();
      t_priority();
      t_host_grant();
      t_suspend();
      t_dma();
      t_rotate();
      complete_run();
   end
   // Watchdog, well beyond the 90 cycles the scenarios need
   initial begin
      #(3000 * 50);
      n_fail++;
      complete_run();
   end
endmodule // sbah_arbiter_tb
`default_nettype wire
